// ### src/bdp_core.sv
// Purpose: opcode timing decoder, instruction cycle sequencer, timer
//          prescale and dual data pointer registers
// Assumes: one clock, synchronous active high reset
// Notes:   one instruction is taken at a time from the issue port
//          unmapped register reads return zero
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "bdp_defs.svh"

module bdp_core (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic        ISSUE,
  input  wire logic [7:0]  OPCODE,
  input  wire logic [7:0]  ACC,
  output logic             BUSY,
  output logic             DONE,
  output logic      [2:0]  INSTR_BYTES,
  output logic      [3:0]  INSTR_CYCLES,
  output logic      [15:0] PTR_ADDR,
  output logic      [15:0] IND_TARGET,
  output logic             XDATA_ACTIVE,
  output logic             CYCLE_TICK,
  output logic             TIMER_TICK
);
  import bdp_pkg::*;

  typedef struct packed {
    bdp_state_t  state;
    logic [1:0]  phase;
    logic [3:0]  left;
    logic [7:0]  p0_low;
    logic [7:0]  p0_high;
    logic [7:0]  p1_low;
    logic [7:0]  p1_high;
    logic        sel;
    logic [7:0]  wait_ctl;
    logic        tmr_fast;
    logic [3:0]  tmr_cnt;
    logic [7:0]  rdata;
    logic        done;
    logic [2:0]  ibytes;
    logic [3:0]  icycles;
    logic        xdata;
    logic [15:0] ind_target;
    logic        tmr_tick;
    logic        cyc_tick;
  } bdp_regs_t;

  bdp_regs_t r;
  bdp_regs_t next_r;

  ////////////////////////////////////////////////////////////////////////
  // opcode decode: bytes, cycles and pointer use
  function automatic bdp_info_t decode(input logic [7:0] op,
                                       input logic [2:0] wait_bits);
    bdp_info_t i;
    // unlisted opcodes default to one byte and one cycle
    i.ibytes   = 3'h1;
    i.icycles  = 4'h1;
    i.uses_ptr = 1'b0;
    i.xdata    = 1'b0;
    i.tgt      = TGT_NONE;
    if (op == `BDP_OP_NOP || op == `BDP_OP_RSVD_NOP) begin
      i.icycles = 4'h1;
    // page call, page bits ride in the top three opcode bits
    end else if (op[4:0] == `BDP_PAGE_CALL_LO) begin
      i.ibytes  = 3'h2;
      i.icycles = 4'h3;
      i.tgt     = TGT_ABS;
    // page jump shares the page call layout
    end else if (op[4:0] == `BDP_PAGE_JUMP_LO) begin
      i.ibytes  = 3'h2;
      i.icycles = 4'h3;
      i.tgt     = TGT_ABS;
    end else if (op == `BDP_OP_FAR_CALL || op == `BDP_OP_FAR_JUMP) begin
      i.ibytes  = 3'h3;
      i.icycles = 4'h4;
      i.tgt     = TGT_ABS;
    // subroutine and interrupt exits
    end else if (op == `BDP_OP_SUB_EXIT || op == `BDP_OP_INT_EXIT) begin
      i.ibytes  = 3'h1;
      i.icycles = 4'h4;
      i.tgt     = TGT_ABS;
    end else if (op == `BDP_OP_NEAR_JUMP || op == `BDP_OP_CARRY ||
                 op == `BDP_OP_NO_CARRY) begin
      i.ibytes  = 3'h2;
      i.icycles = 4'h3;
      i.tgt     = TGT_REL;
    // bit test branches; the bit clear is done by the bit unit
    end else if (op == `BDP_OP_BIT_SET || op == `BDP_OP_BIT_NOT ||
                 op == `BDP_OP_BIT_CLEAR) begin
      i.ibytes  = 3'h3;
      i.icycles = 4'h4;
      i.tgt     = TGT_REL;
    end else if (op == `BDP_OP_IND_JUMP) begin
      i.ibytes   = 3'h1;
      i.icycles  = 4'h3;
      i.uses_ptr = 1'b1;
      i.tgt      = TGT_IND;
    end else if (op == `BDP_OP_ACC_ZERO || op == `BDP_OP_ACC_NZ) begin
      i.ibytes  = 3'h2;
      i.icycles = 4'h3;
      i.tgt     = TGT_REL;
    end else if (op == `BDP_OP_CMP_DIR || op == `BDP_OP_CMP_IMM_A ||
                 op[7:3] == `BDP_CMP_REG_HI || op[7:1] == `BDP_CMP_IND_HI) begin
      i.ibytes  = 3'h3;
      i.icycles = 4'h4;
      i.tgt     = TGT_REL;
    end else if (op[7:3] == `BDP_DEC_REG_HI) begin
      i.ibytes  = 3'h2;
      i.icycles = 4'h3;
      i.tgt     = TGT_REL;
    // direct form costs one cycle more
    end else if (op == `BDP_OP_DEC_DIR) begin
      i.ibytes  = 3'h3;
      i.icycles = 4'h4;
      i.tgt     = TGT_REL;
    end else if (op == `BDP_OP_COPY_DD) begin
      i.ibytes  = 3'h3;
      i.icycles = 4'h3;
    // product and quotient exceed their byte count
    end else if (op == `BDP_OP_PRODUCT || op == `BDP_OP_QUOTIENT) begin
      i.ibytes  = 3'h1;
      i.icycles = 4'h5;
    // external transfers stretch by the wait bits
    end else if (op == `BDP_OP_XRD_PTR || op == `BDP_OP_XWR_PTR ||
                 op[7:1] == `BDP_XRD_RI_HI || op[7:1] == `BDP_XWR_RI_HI) begin
      i.ibytes   = 3'h1;
      i.icycles  = 4'({1'b0, `BDP_XDATA_BASE} + {1'b0, wait_bits});
      i.xdata    = 1'b1;
      i.uses_ptr = (op == `BDP_OP_XRD_PTR || op == `BDP_OP_XWR_PTR);
    // pointer load uses the selected pointer
    end else if (op == `BDP_OP_MOV_PTR) begin
      i.ibytes   = 3'h3;
      i.icycles  = 4'h3;
      i.uses_ptr = 1'b1;
    // code reads relative to the pointer or to the program counter
    end else if (op == `BDP_OP_CODE_PTR || op == `BDP_OP_CODE_PC) begin
      i.ibytes   = 3'h1;
      i.icycles  = 4'h3;
      i.uses_ptr = (op == `BDP_OP_CODE_PTR);
    end
    return i;
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////
  // register address decode, shared by the write and read paths
  function automatic logic [2:0] reg_code(input logic [7:0] a);
    logic [2:0] c;
    c = `BDP_REG_NONE;
    if (a == `BDP_ADDR_P0_LOW) begin
      c = `BDP_REG_P0L;
    end else if (a == `BDP_ADDR_P0_HIGH) begin
      c = `BDP_REG_P0H;
    end else if (a == `BDP_ADDR_P1_LOW) begin
      c = `BDP_REG_P1L;
    end else if (a == `BDP_ADDR_P1_HIGH) begin
      c = `BDP_REG_P1H;
    end else if (a == `BDP_ADDR_CHOICE) begin
      c = `BDP_REG_CHOICE;
    end else if (a == `BDP_ADDR_WAIT) begin
      c = `BDP_REG_WAIT;
    end else if (a == `BDP_ADDR_TMR_CTRL) begin
      c = `BDP_REG_TMR;
    end
    return c;
  endfunction : reg_code

  bdp_info_t   info;
  logic [15:0] sel_ptr;
  logic [2:0]  reg_sel;
  logic [3:0]  tmr_div;

  ////////////////////////////////////////////////////////////////////////
  // selected pointer
  assign sel_ptr = r.sel ? {r.p1_high, r.p1_low} : {r.p0_high, r.p0_low};
  assign info    = decode(OPCODE, r.wait_ctl[2:0]);
  assign reg_sel = reg_code(ADDR);
  // prescale limit follows the speed bit
  assign tmr_div = r.tmr_fast ? `BDP_TMR_FAST_DIV : `BDP_TMR_SLOW_DIV;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r          = r;
    next_r.done     = 1'b0;
    next_r.tmr_tick = 1'b0;
    next_r.cyc_tick = 1'b0;
    next_r.rdata    = 8'h00;

    // register writes
    if (WR) begin
      if (reg_sel == `BDP_REG_P0L) begin
        next_r.p0_low = WDATA;
      end else if (reg_sel == `BDP_REG_P0H) begin
        next_r.p0_high = WDATA;
      end else if (reg_sel == `BDP_REG_P1L) begin
        next_r.p1_low = WDATA;
      end else if (reg_sel == `BDP_REG_P1H) begin
        next_r.p1_high = WDATA;
      end else if (reg_sel == `BDP_REG_CHOICE) begin
        next_r.sel = WDATA[0];
      end else if (reg_sel == `BDP_REG_WAIT) begin
        next_r.wait_ctl = WDATA;
      end else if (reg_sel == `BDP_REG_TMR) begin
        next_r.tmr_fast = WDATA[0];
      end
    end

    // register reads, data in the next cycle
    if (RD) begin
      if (reg_sel == `BDP_REG_P0L) begin
        next_r.rdata = r.p0_low;
      end else if (reg_sel == `BDP_REG_P0H) begin
        next_r.rdata = r.p0_high;
      end else if (reg_sel == `BDP_REG_P1L) begin
        next_r.rdata = r.p1_low;
      end else if (reg_sel == `BDP_REG_P1H) begin
        next_r.rdata = r.p1_high;
      end else if (reg_sel == `BDP_REG_CHOICE) begin
        next_r.rdata = {`BDP_CHOICE_FIXED, r.sel};
      end else if (reg_sel == `BDP_REG_WAIT) begin
        next_r.rdata = r.wait_ctl;
      // timer speed bit, upper bits fixed
      end else if (reg_sel == `BDP_REG_TMR) begin
        next_r.rdata = {`BDP_TMR_CTRL_FIXED, r.tmr_fast};
      end
    end

    // timer prescale; a count past a shortened limit wraps at once
    if (r.tmr_cnt >= tmr_div - 4'h1) begin
      next_r.tmr_cnt  = 4'h0;
      next_r.tmr_tick = 1'b1;
    end else begin
      next_r.tmr_cnt = r.tmr_cnt + 4'h1;
    end

    // instruction sequencer
    case (r.state)
      ST_IDLE: begin
        if (ISSUE) begin
          next_r.state      = ST_EXEC;
          next_r.phase      = 2'h0;
          next_r.left       = info.icycles;
          next_r.ibytes     = info.ibytes;
          next_r.icycles    = info.icycles;
          next_r.xdata      = info.xdata;
          next_r.ind_target = sel_ptr + {8'h00, ACC};
        end
      end
      ST_EXEC: begin
        if (r.phase == 2'(`BDP_CLK_PER_ICYC - 3'h1)) begin
          next_r.phase    = 2'h0;
          next_r.cyc_tick = 1'b1;
          // transfer flag drops with the last cycle
          if (r.left == 4'h1) begin
            next_r.state = ST_IDLE;
            next_r.done  = 1'b1;
            next_r.xdata = 1'b0;
          end
          next_r.left = r.left - 4'h1;
        end else begin
          next_r.phase = r.phase + 2'h1;
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // reset clears pointers and choice
  always_ff @(posedge CLK) begin
    if (RESET) begin
      r          <= '0;
      r.state    <= ST_IDLE;
      r.wait_ctl <= `BDP_WAIT_RESET;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign RDATA        = r.rdata;
  assign BUSY         = (r.state == ST_EXEC);
  assign DONE         = r.done;
  assign INSTR_BYTES  = r.ibytes;
  assign INSTR_CYCLES = r.icycles;
  assign PTR_ADDR     = sel_ptr;
  assign IND_TARGET   = r.ind_target;
  assign XDATA_ACTIVE = r.xdata;
  assign CYCLE_TICK   = r.cyc_tick;
  assign TIMER_TICK   = r.tmr_tick;

endmodule : bdp_core

// ### src/bdp_defs.svh
// Purpose: constants for the branch timing and dual pointer block
// Assumes: included by the design file
// Notes:   register addresses are special register addresses
`ifndef BDP_DEFS_SVH
`define BDP_DEFS_SVH

`define BDP_ADDR_P0_LOW    8'h82
`define BDP_ADDR_P0_HIGH   8'h83
`define BDP_ADDR_P1_LOW    8'h84
`define BDP_ADDR_P1_HIGH   8'h85
`define BDP_ADDR_CHOICE    8'h86
`define BDP_ADDR_WAIT      8'h8e
`define BDP_ADDR_TMR_CTRL  8'h8f
`define BDP_CHOICE_FIXED   7'h00
`define BDP_CLK_PER_ICYC   3'h4
`define BDP_TMR_SLOW_DIV   4'hc
`define BDP_TMR_FAST_DIV   4'h4
`define BDP_XDATA_BASE     3'h2
`define BDP_XDATA_MAX      4'ha
`define BDP_WAIT_RESET     8'h01
`define BDP_OP_NOP         8'h00
`define BDP_OP_RSVD_NOP    8'ha5
`define BDP_OP_FAR_CALL    8'h12
`define BDP_OP_FAR_JUMP    8'h02
`define BDP_OP_NEAR_JUMP   8'h80
`define BDP_OP_SUB_EXIT    8'h22
`define BDP_OP_INT_EXIT    8'h32
`define BDP_OP_BIT_CLEAR   8'h10
`define BDP_OP_BIT_SET     8'h20
`define BDP_OP_BIT_NOT     8'h30
`define BDP_OP_CARRY       8'h40
`define BDP_OP_NO_CARRY    8'h50
`define BDP_OP_ACC_ZERO    8'h60
`define BDP_OP_ACC_NZ      8'h70
`define BDP_OP_IND_JUMP    8'h73
`define BDP_OP_CMP_IMM_A   8'hb4
`define BDP_OP_CMP_DIR     8'hb5
`define BDP_OP_DEC_DIR     8'hd5
`define BDP_OP_PRODUCT     8'ha4
`define BDP_OP_QUOTIENT    8'h84
`define BDP_OP_COPY_DD     8'h85
`define BDP_OP_XRD_PTR     8'he0
`define BDP_OP_XWR_PTR     8'hf0
`define BDP_OP_MOV_PTR     8'h90
`define BDP_OP_CODE_PTR    8'h93
`define BDP_OP_CODE_PC     8'h83
`define BDP_PAGE_CALL_LO   5'h11
`define BDP_PAGE_JUMP_LO   5'h01
`define BDP_CMP_REG_HI     5'h17
`define BDP_CMP_IND_HI     7'h5b
`define BDP_DEC_REG_HI     5'h1b
`define BDP_XRD_RI_HI      7'h71
`define BDP_XWR_RI_HI      7'h79
`define BDP_TMR_CTRL_FIXED 7'h00
`define BDP_REG_NONE       3'h0
`define BDP_REG_P0L        3'h1
`define BDP_REG_P0H        3'h2
`define BDP_REG_P1L        3'h3
`define BDP_REG_P1H        3'h4
`define BDP_REG_CHOICE     3'h5
`define BDP_REG_WAIT       3'h6
`define BDP_REG_TMR        3'h7

`endif

// ### src/bdp_pkg.sv
// Purpose: types for the branch timing and dual pointer block
// Assumes: nothing
// Notes:   constants live in bdp_defs.svh
package bdp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC} bdp_state_t;
  typedef enum logic [1:0] {TGT_NONE, TGT_REL, TGT_ABS, TGT_IND} bdp_tgt_t;
  typedef struct packed {
    logic [2:0] ibytes;
    logic [3:0] icycles;
    logic       uses_ptr;
    logic       xdata;
    bdp_tgt_t   tgt;
  } bdp_info_t;
endpackage : bdp_pkg

// ### testbench/bdp_chk.sv
// Purpose: timing and register checks at the core ports
// Assumes: one clock, reset synchronous active high
// Notes:   done comes 4*N+1 cycles after the issue edge
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module bdp_chk (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic [7:0]  ADDR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  input wire logic        ISSUE,
  input wire logic [7:0]  OPCODE,
  input wire logic [7:0]  ACC,
  input wire logic        BUSY,
  input wire logic        DONE,
  input wire logic [15:0] PTR_ADDR,
  input wire logic [15:0] IND_TARGET,
  input wire logic        XDATA_ACTIVE,
  input wire logic        CYCLE_TICK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  wire take = ISSUE && !BUSY;
  a_nop_len: assert property (
    take && OPCODE == 8'h00 |-> ##5 DONE) else $error("nop length");
  a_far_call_len: assert property (
    take && OPCODE == 8'h12 |-> ##17 DONE) else $error("far call length");
  a_near_jump_len: assert property (
    take && OPCODE == 8'h80 |-> ##13 DONE) else $error("near jump length");
  a_xfer_flag: assert property (
    take && OPCODE == 8'he0 |-> ##[1:2] XDATA_ACTIVE)
    else $error("transfer not flagged");
  a_ind_target: assert property (
    take && OPCODE == 8'h73 |=> IND_TARGET ==
    $past(PTR_ADDR) + {8'h00, $past(ACC)}) else $error("indirect target");
  a_choice_fixed: assert property (
    RD && ADDR == 8'h86 |=> RDATA[7:1] == 7'h00) else $error("choice bits");
  // read data only after a read
  a_rdata_idle: assert property (
    !$past(RD) |-> RDATA == 8'h00) else $error("read data not idle");
  // done is a lone pulse outside busy
  a_done_pulse: assert property (
    DONE |-> !BUSY ##1 !DONE) else $error("done pulse");
  a_tick_gap: assert property (
    CYCLE_TICK |=> !CYCLE_TICK [*3]) else $error("cycle tick spacing");
  // main scenarios
  c_ind: cover property (take && OPCODE == 8'h73);
  c_xfer: cover property (take && OPCODE == 8'he0);
  c_choice: cover property (RD && ADDR == 8'h86);
endmodule : bdp_chk
bind bdp_core bdp_chk bdp_chk_inst (.*);

// ### testbench/bdp_pmem.sv
// Purpose: program memory model feeding opcodes to the bench
// Assumes: index chosen by the bench, read combinationally
// Notes:   entry is opcode, then byte count, then cycle count
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module bdp_pmem (
  input  wire logic [4:0]  idx,
  output logic      [15:0] word
);
  // program image; sizes follow the opcode tables
  logic [15:0] rom [28] = '{16'h0011, 16'ha511, 16'h1123, 16'hf123,
    16'h1234, 16'h8023, 16'h2034, 16'h3034, 16'h1034, 16'h7313,
    16'h6023, 16'h7023, 16'hb534, 16'hb434, 16'hb834, 16'hbf34,
    16'hb634, 16'hb734, 16'hd823, 16'hdf23, 16'hd534, 16'h0234,
    16'h0123, 16'h2214, 16'h3214, 16'h8533, 16'ha415, 16'he013};
  assign word = rom[idx];
endmodule : bdp_pmem

// ### testbench/testbench.sv
// Purpose: self-checking bench for the branch timing core
// Assumes: core answers per the hand-over contract
// Notes:   expected results queued by drivers, popped by a watcher
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module testbench;
  import bdp_pkg::*;
  logic        CLK = 0, RESET = 1, WR = 0, RD = 0, ISSUE = 0, rd_q = 0;
  logic [7:0]  ADDR = 0, WDATA = 0, OPCODE = 0, ACC = 0, RDATA;
  logic        BUSY, DONE, XDATA_ACTIVE, CYCLE_TICK, TIMER_TICK;
  logic [2:0]  INSTR_BYTES;
  logic [3:0]  INSTR_CYCLES;
  logic [15:0] PTR_ADDR, IND_TARGET, word, p0, p1, iq[$];
  logic [7:0]  rq[$];
  logic [4:0]  idx = 0;
  integer      seed = 87944;
  int          errors = 0, compares = 0, cnt = 0, i;
  bdp_core bdp_core_inst (.*);
  bdp_pmem bdp_pmem_inst (.idx(idx), .word(word));
  always #2 CLK = ~CLK;
  task automatic check(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  // result watcher: pops the oldest note per result
  always @(posedge CLK) begin
    cnt <= (ISSUE && !BUSY) ? 1 : cnt + 1;
    rd_q <= RD;
    if (rd_q) check(RDATA, rq.pop_front());
    if (DONE) check({INSTR_BYTES, INSTR_CYCLES, 6'(cnt)}, iq.pop_front());
  end
  task automatic wr(input logic [7:0] a, d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    rq.push_back(e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
  endtask : rd
  // issue one opcode; poke retries while busy and must be ignored
  task automatic run(input logic [7:0] op, input logic [2:0] b,
                     input logic [3:0] c, input bit poke);
    int k;
    iq.push_back({b, c, 6'(4 * c + 1)});
    @(posedge CLK);
    OPCODE <= op;
    ACC <= 8'($random(seed));
    ISSUE <= 1'b1;
    @(posedge CLK);
    ISSUE <= 1'b0;
    if (poke) begin
      repeat (2) @(posedge CLK);
      OPCODE <= 8'h00;
      ISSUE <= 1'b1;
      @(posedge CLK);
      ISSUE <= 1'b0;
    end
    for (k = 0; k < 60 && !DONE; k++) @(negedge CLK);
    if (!DONE) begin
      errors++;
      wrap_up();
    end
  endtask : run
  // measure spacing of timer ticks
  task automatic tick(input int e);
    int n;
    for (n = 0; n < 40 && !TIMER_TICK; n++) @(negedge CLK);
    @(negedge CLK);
    for (n = 1; n < 40 && !TIMER_TICK; n++) @(negedge CLK);
    check(16'(n), 16'(e));
  endtask : tick
  // main sequence
  initial begin
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    for (i = 2; i < 7; i++) rd(8'(8'h80 + i), 8'h00);
    rd(8'h8e, 8'h01);
    rd(8'h80, 8'h00);
    p0 = 16'($random(seed));
    p1 = 16'($random(seed));
    wr(8'h82, p0[7:0]);
    wr(8'h83, p0[15:8]);
    wr(8'h84, p1[7:0]);
    wr(8'h85, p1[15:8]);
    rd(8'h83, p0[15:8]);
    rd(8'h84, p1[7:0]);
    run(8'h73, 3'h1, 4'h3, 0);
    check(IND_TARGET, p0 + ACC);
    wr(8'h86, 8'h00 + 8'h01);
    @(negedge CLK);
    check(PTR_ADDR, p1);
    run(8'h73, 3'h1, 4'h3, 0);
    check(IND_TARGET, p1 + ACC);
    wr(8'h86, 8'hff);
    rd(8'h86, 8'h01);
    wr(8'h86, 8'h02);
    rd(8'h86, 8'h00);
    for (i = 0; i < 28; i++) begin
      idx = 5'(i);
      #1;
      run(word[15:8], word[6:4], word[3:0], 0);
    end
    run(8'h12, 3'h3, 4'h4, 1);
    wr(8'h8e, 8'h00);
    run(8'he0, 3'h1, 4'h2, 0);
    wr(8'h8e, 8'hf7);
    run(8'hf0, 3'h1, 4'h9, 0);
    tick(12);
    wr(8'h8f, 8'h01);
    tick(4);
    check(16'(iq.size()), 16'h0000);
    wrap_up();
  end
endmodule : testbench
